/* pdc_pkg.sv */
// ==========================================================================
// Overview of operation
// [R1] wake wait counts 8192..16 states per select
// [R2] sleep-kind, low-speed, direct flags pick sleep target
// [R3] active divider: 0xx undivided, else /8../64
// [R4] sub divider of watch clock: /8, /4, /2
// [R5] new divider value applies only after sleep
// [R6] bit 6 puts two-wire bus in standby
// [R7] bit 5 puts async serial in standby
// [R8] bit 4 puts converter control in standby
// [R9] bit 3 watchdog standby unless internal oscillator
// [R10] bit 2 puts timer w in standby
// [R11] bit 1 puts timer v in standby
// [R12] bit 0 puts timer a in standby
// [R13] standby register bit 7 reads zero
// [R14] wait applied on wake into active/sleep; code waits only out of standby or subsleep, then goes to active
// [R15] sleep instruction target follows flag table
// [R16] software standby bit selects standby target
// [R17] writes to reserved standby bit ignored
package pdc_pkg;
    // ======================================================================
    // register map, one byte per index
    localparam logic [1:0] ADDR_WAIT_CTRL = 2'h0;
    localparam logic [1:0] ADDR_MODE_CLK = 2'h1;
    localparam logic [1:0] ADDR_PERIPH_SBY = 2'h2;
    localparam logic [1:0] ADDR_STATUS = 2'h3;
    localparam logic [7:0] RST_WAIT_CTRL = 8'h00;
    localparam logic [7:0] RST_MODE_CLK = 8'h00;
    localparam logic [7:0] RST_PERIPH_SBY = 8'h00;
    // ======================================================================
    // field positions
    localparam int POS_SOFT_STANDBY = 7;
    localparam int POS_WAIT_SEL_LO = 4;
    localparam int POS_SLEEP_KIND = 7;
    localparam int POS_LOW_SPEED = 6;
    localparam int POS_DIRECT = 5;
    localparam int POS_ACT_DIV_LO = 2;
    localparam int POS_SUB_DIV_LO = 0;
    localparam int POS_WDT_SBY = 3;
    localparam int POS_RESERVED_SBY = 7;
    localparam logic [7:0] PERIPH_SBY_MASK = 8'h7f;
    // ======================================================================
    // wake wait counts in states (system clock cycles)
    localparam int unsigned WAIT_CNT_0 = 8192;
    localparam int unsigned WAIT_CNT_1 = 16384;
    localparam int unsigned WAIT_CNT_2 = 32768;
    localparam int unsigned WAIT_CNT_3 = 65536;
    localparam int unsigned WAIT_CNT_4 = 131072;
    localparam logic [17:0] WAIT_CNT_5 = 18'h00400;
    localparam logic [17:0] WAIT_CNT_6 = 18'h00080;
    localparam logic [17:0] WAIT_CNT_7 = 18'h00010;
    // settling time software should reach, checked for status only
    localparam int unsigned CLK_PERIOD_PS = 4000;
    localparam longint unsigned SETTLE_MIN_PS = 64'd6500000000;
    localparam longint unsigned SETTLE_MIN_CYC =
        (SETTLE_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // divider ratios as log2
    localparam logic [2:0] ACT_SHIFT_BASE = 3'h3;
    localparam logic [2:0] SUB_SHIFT_DIV8 = 3'h3;
    localparam logic [2:0] SUB_SHIFT_DIV4 = 3'h2;
    localparam logic [2:0] SUB_SHIFT_DIV2 = 3'h1;
    // ======================================================================
    typedef enum logic [2:0] {
        PDC_ACTIVE,
        PDC_SLEEP,
        PDC_SUBACTIVE,
        PDC_SUBSLEEP,
        PDC_STANDBY,
        PDC_WAKE_WAIT
    } pdc_mode_t;
endpackage

/* pdc_clk_div.sv */
`timescale 1ns/100ps
// ==========================================================================
// power-of-two tick divider
module pdc_clk_div (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // source tick and ratio
    input wire logic i_tick,
    input wire logic [2:0] i_shift,
    // divided tick
    output logic o_tick
);
    logic [5:0] cnt;
    logic [5:0] next_cnt;
    logic next_tick;
    logic [5:0] mask;

    // mask of counter bits that must all be one before a tick passes
    always_comb begin
        mask = 6'((7'h01 << i_shift) - 7'h01);
        next_cnt = cnt;
        next_tick = 1'b0;
        if (i_tick) begin
            if ((cnt & mask) == mask) begin
                next_tick = 1'b1;
                next_cnt = 6'h00;
            end else begin
                next_cnt = cnt + 6'h01;
            end
        end
    end

    // registered so the tick is glitch free
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            cnt <= 6'h00;
            o_tick <= 1'b0;
        end else begin
            cnt <= next_cnt;
            o_tick <= next_tick;
        end
    end
endmodule // pdc_clk_div

/* pdc_power_ctrl.sv */
`timescale 1ns/100ps
// ==========================================================================
// power-down and clock control
module pdc_power_ctrl #(
    parameter int unsigned P_WAIT_CNT_0 = pdc_pkg::WAIT_CNT_0,
    parameter int unsigned P_WAIT_CNT_1 = pdc_pkg::WAIT_CNT_1,
    parameter int unsigned P_WAIT_CNT_2 = pdc_pkg::WAIT_CNT_2,
    parameter int unsigned P_WAIT_CNT_3 = pdc_pkg::WAIT_CNT_3,
    parameter int unsigned P_WAIT_CNT_4 = pdc_pkg::WAIT_CNT_4
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // register port
    input wire logic [1:0] i_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rd_data,
    // cpu events and status
    input wire logic i_sleep,
    input wire logic i_wake,
    input wire logic i_wdt_int_osc,
    // watch clock pin
    input wire logic i_watch_clk,
    // mode and clock outputs
    output logic [2:0] o_mode,
    output logic o_cpu_run,
    output logic o_periph_run,
    output logic o_clk_en,
    // module standby outputs, bit order as in the register
    output logic [6:0] o_mod_standby
);
    // ======================================================================
    // register state
    logic [7:0] wait_ctrl;
    logic [7:0] mode_clk;
    logic [7:0] periph_sby;
    logic [7:0] next_wait_ctrl;
    logic [7:0] next_mode_clk;
    logic [7:0] next_periph_sby;
    logic [7:0] next_rd_data;
    logic [6:0] next_mod_standby;

    // fields
    logic soft_standby_bit;
    logic [2:0] wake_wait_select;
    logic sleep_kind_select;
    logic low_speed_flag;
    logic direct_transfer_flag;
    logic [2:0] active_div;
    logic [1:0] sub_div;

    assign soft_standby_bit = wait_ctrl[pdc_pkg::POS_SOFT_STANDBY];
    assign wake_wait_select = wait_ctrl[pdc_pkg::POS_WAIT_SEL_LO +: 3];
    assign sleep_kind_select = mode_clk[pdc_pkg::POS_SLEEP_KIND];
    assign low_speed_flag = mode_clk[pdc_pkg::POS_LOW_SPEED];
    assign direct_transfer_flag = mode_clk[pdc_pkg::POS_DIRECT];
    assign active_div = mode_clk[pdc_pkg::POS_ACT_DIV_LO +: 3];
    assign sub_div = mode_clk[pdc_pkg::POS_SUB_DIV_LO +: 2];

    // ======================================================================
    // functions
    function automatic logic [2:0] act_shift(input logic [2:0] code);
        if (!code[2]) begin
            return 3'h0; // [R3]
        end
        return pdc_pkg::ACT_SHIFT_BASE + {1'b0, code[1:0]}; // [R3]
    endfunction

    function automatic logic [2:0] sub_shift(input logic [1:0] code);
        if (code[1]) begin
            return pdc_pkg::SUB_SHIFT_DIV2; // [R4]
        end
        return code[0] ? pdc_pkg::SUB_SHIFT_DIV4 : pdc_pkg::SUB_SHIFT_DIV8; // [R4]
    endfunction

    function automatic logic [17:0] wait_count(input logic [2:0] sel);
        logic [17:0] cnt;
        unique case (sel)
            3'h0: cnt = 18'(P_WAIT_CNT_0); // [R1]
            3'h1: cnt = 18'(P_WAIT_CNT_1);
            3'h2: cnt = 18'(P_WAIT_CNT_2);
            3'h3: cnt = 18'(P_WAIT_CNT_3);
            3'h4: cnt = 18'(P_WAIT_CNT_4);
            3'h5: cnt = pdc_pkg::WAIT_CNT_5;
            3'h6: cnt = pdc_pkg::WAIT_CNT_6;
            3'h7: cnt = pdc_pkg::WAIT_CNT_7;
        endcase
        return cnt;
    endfunction

    // ======================================================================
    // mode machine state
    pdc_pkg::pdc_mode_t mode;
    pdc_pkg::pdc_mode_t next_mode;
    logic [17:0] wait_cnt;
    logic [17:0] next_wait_cnt;
    logic [2:0] act_applied;
    logic [2:0] next_act_applied;
    logic [2:0] sub_applied;
    logic [2:0] next_sub_applied;
    logic sleep_take;
    logic wake_take;
    logic next_cpu_run;
    logic next_periph_run;
    logic next_clk_en;
    logic settle_short;

    // watch clock pin sync and edge
    logic watch_s1;
    logic watch_s2;
    logic watch_s3;
    logic watch_rise;
    logic act_tick;
    logic sub_tick;

    // sleep is only meaningful while the program runs
    assign sleep_take = i_sleep && (mode == pdc_pkg::PDC_ACTIVE ||
                                    mode == pdc_pkg::PDC_SUBACTIVE);
    assign wake_take = i_wake && (mode == pdc_pkg::PDC_SLEEP ||
                                  mode == pdc_pkg::PDC_SUBSLEEP ||
                                  mode == pdc_pkg::PDC_STANDBY);
    assign watch_rise = watch_s2 && !watch_s3;
    // status only: the selected wait is shorter than the settling time
    assign settle_short =
        64'(wait_count(wake_wait_select)) < pdc_pkg::SETTLE_MIN_CYC; // [R14]

    // ======================================================================
    // register file next values
    always_comb begin
        next_wait_ctrl = wait_ctrl;
        next_mode_clk = mode_clk;
        next_periph_sby = periph_sby;
        next_rd_data = 8'h00;
        if (i_wr) begin
            unique case (i_addr)
                pdc_pkg::ADDR_WAIT_CTRL: next_wait_ctrl = i_wr_data & 8'hf0;
                pdc_pkg::ADDR_MODE_CLK: next_mode_clk = i_wr_data;
                // reserved top bit dropped so it always reads zero
                pdc_pkg::ADDR_PERIPH_SBY: next_periph_sby =
                    i_wr_data & pdc_pkg::PERIPH_SBY_MASK; // [R17]
                default: ;
            endcase
        end
        if (i_rd) begin
            unique case (i_addr)
                pdc_pkg::ADDR_WAIT_CTRL: next_rd_data = wait_ctrl;
                pdc_pkg::ADDR_MODE_CLK: next_rd_data = mode_clk;
                pdc_pkg::ADDR_PERIPH_SBY: next_rd_data =
                    periph_sby & pdc_pkg::PERIPH_SBY_MASK; // [R13]
                pdc_pkg::ADDR_STATUS: next_rd_data =
                    {3'h0, settle_short, o_cpu_run, o_mode};
            endcase
        end
        // watchdog keeps running on the internal oscillator
        next_mod_standby = periph_sby[6:0]; // [R6] [R7] [R8] [R10] [R11] [R12]
        next_mod_standby[pdc_pkg::POS_WDT_SBY] =
            periph_sby[pdc_pkg::POS_WDT_SBY] && !i_wdt_int_osc; // [R9]
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            wait_ctrl <= pdc_pkg::RST_WAIT_CTRL;
            mode_clk <= pdc_pkg::RST_MODE_CLK;
            periph_sby <= pdc_pkg::RST_PERIPH_SBY;
            o_rd_data <= 8'h00;
            o_mod_standby <= 7'h00;
        end else begin
            wait_ctrl <= next_wait_ctrl;
            mode_clk <= next_mode_clk;
            periph_sby <= next_periph_sby;
            o_rd_data <= next_rd_data;
            o_mod_standby <= next_mod_standby;
        end
    end

    // ======================================================================
    // mode machine next values
    always_comb begin
        next_mode = mode;
        next_wait_cnt = wait_cnt;
        next_act_applied = act_applied;
        next_sub_applied = sub_applied;
        if (sleep_take) begin
            // dividers take the register value only here
            next_act_applied = act_shift(active_div); // [R5]
            next_sub_applied = sub_shift(sub_div); // [R5]
        end
        unique case (mode)
            pdc_pkg::PDC_ACTIVE, pdc_pkg::PDC_SUBACTIVE: begin
                if (sleep_take) begin
                    if (direct_transfer_flag) begin
                        next_mode = low_speed_flag ? pdc_pkg::PDC_SUBACTIVE
                                                   : pdc_pkg::PDC_ACTIVE; // [R15]
                    end else if (soft_standby_bit) begin
                        next_mode = pdc_pkg::PDC_STANDBY; // [R16]
                    end else begin
                        next_mode = sleep_kind_select ? pdc_pkg::PDC_SUBSLEEP
                                                      : pdc_pkg::PDC_SLEEP; // [R2] [R16]
                    end
                end
            end
            pdc_pkg::PDC_SLEEP, pdc_pkg::PDC_SUBSLEEP, pdc_pkg::PDC_STANDBY: begin
                if (wake_take) begin
                    if (mode == pdc_pkg::PDC_SLEEP) begin
                        // oscillator never stopped, no settling needed
                        next_mode = low_speed_flag ? pdc_pkg::PDC_SUBACTIVE
                                                   : pdc_pkg::PDC_ACTIVE;
                    end else if (mode == pdc_pkg::PDC_SUBSLEEP && low_speed_flag) begin
                        next_mode = pdc_pkg::PDC_SUBACTIVE;
                    end else begin
                        next_mode = pdc_pkg::PDC_WAKE_WAIT; // [R14]
                        next_wait_cnt = wait_count(wake_wait_select) - 18'h00001; // [R1]
                    end
                end
            end
            pdc_pkg::PDC_WAKE_WAIT: begin
                if (wait_cnt == 18'h00000) begin
                    next_mode = pdc_pkg::PDC_ACTIVE; // [R1]
                end else begin
                    next_wait_cnt = wait_cnt - 18'h00001;
                end
            end
            default: next_mode = pdc_pkg::PDC_ACTIVE;
        endcase
        next_cpu_run = next_mode == pdc_pkg::PDC_ACTIVE ||
                       next_mode == pdc_pkg::PDC_SUBACTIVE; // [R1]
        next_periph_run = next_mode != pdc_pkg::PDC_STANDBY &&
                          next_mode != pdc_pkg::PDC_WAKE_WAIT; // [R1]
        // subclock modes run from the watch clock divider
        if (mode == pdc_pkg::PDC_ACTIVE || mode == pdc_pkg::PDC_SLEEP) begin
            next_clk_en = act_tick; // [R3]
        end else if (mode == pdc_pkg::PDC_SUBACTIVE || mode == pdc_pkg::PDC_SUBSLEEP) begin
            next_clk_en = sub_tick; // [R4]
        end else begin
            next_clk_en = 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            mode <= pdc_pkg::PDC_ACTIVE;
            wait_cnt <= 18'h00000;
            act_applied <= 3'h0;
            sub_applied <= pdc_pkg::SUB_SHIFT_DIV8;
            o_mode <= 3'h0;
            o_cpu_run <= 1'b1;
            o_periph_run <= 1'b1;
            o_clk_en <= 1'b0;
            watch_s1 <= 1'b0;
            watch_s2 <= 1'b0;
            watch_s3 <= 1'b0;
        end else begin
            mode <= next_mode;
            wait_cnt <= next_wait_cnt;
            act_applied <= next_act_applied;
            sub_applied <= next_sub_applied;
            o_mode <= next_mode;
            o_cpu_run <= next_cpu_run;
            o_periph_run <= next_periph_run;
            o_clk_en <= next_clk_en;
            watch_s1 <= i_watch_clk;
            watch_s2 <= watch_s1;
            watch_s3 <= watch_s2;
        end
    end

    // ======================================================================
    // clock dividers
    pdc_clk_div u_act_div (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_tick(1'b1),
        .i_shift(act_applied),
        .o_tick(act_tick)
    );

    pdc_clk_div u_sub_div (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_tick(watch_rise),
        .i_shift(sub_applied),
        .o_tick(sub_tick)
    );

    // ======================================================================
    // checks
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    logic [17:0] hold_cnt;
    logic [17:0] hold_target;
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            hold_cnt <= 18'h00000;
            hold_target <= 18'h00000;
        end else if (mode != pdc_pkg::PDC_WAKE_WAIT) begin
            hold_cnt <= 18'h00000;
            hold_target <= wait_count(wake_wait_select);
        end else begin
            hold_cnt <= hold_cnt + 18'h00001;
        end
    end

    chk_wait_length: assert property ( // [R1]
        mode == pdc_pkg::PDC_WAKE_WAIT && next_mode != pdc_pkg::PDC_WAKE_WAIT
        |-> hold_cnt == hold_target - 18'h00001 && !o_cpu_run)
        else $error("wake wait length wrong");
    chk_sleep_entry: assert property ( // [R2]
        sleep_take && !direct_transfer_flag && !soft_standby_bit
        |=> (o_mode == ($past(sleep_kind_select) ? 3'(pdc_pkg::PDC_SUBSLEEP)
                                                 : 3'(pdc_pkg::PDC_SLEEP))) && !o_cpu_run)
        else $error("sleep target wrong");
    chk_standby_entry: assert property ( // [R16]
        sleep_take && !direct_transfer_flag && soft_standby_bit
        |=> mode == pdc_pkg::PDC_STANDBY ##1 !o_periph_run)
        else $error("standby not entered");
    chk_direct_move: assert property ( // [R15]
        sleep_take && direct_transfer_flag && low_speed_flag
        |=> mode == pdc_pkg::PDC_SUBACTIVE && o_cpu_run)
        else $error("direct transfer wrong");
    chk_div_hold: assert property ( // [R5]
        !sleep_take |=> $stable(act_applied) && $stable(sub_applied))
        else $error("divider changed without sleep");
    chk_div_load: assert property ( // [R3]
        sleep_take && active_div == 3'h5 |=> act_applied == 3'h4)
        else $error("active divider code wrong");
    chk_wdt_gate: assert property ( // [R9]
        i_wdt_int_osc |=> !o_mod_standby[pdc_pkg::POS_WDT_SBY])
        else $error("watchdog stopped on internal oscillator");
    chk_reserved_zero: assert property ( // [R13]
        i_rd && i_addr == pdc_pkg::ADDR_PERIPH_SBY |=> !o_rd_data[7])
        else $error("reserved standby bit read as one");
    chk_standby_bits: assert property ( // [R6]
        i_wr && i_addr == pdc_pkg::ADDR_PERIPH_SBY
        |=> ##1 o_mod_standby[6:4] == $past(i_wr_data[6:4], 2)
            && o_mod_standby[2:0] == $past(i_wr_data[2:0], 2))
        else $error("standby outputs not following register");
    chk_wake_wait: assert property ( // [R14]
        wake_take && mode == pdc_pkg::PDC_STANDBY
        |=> mode == pdc_pkg::PDC_WAKE_WAIT ##1 !o_cpu_run)
        else $error("standby wake skipped wait");

    cov_sleep_wake: cover property (
        mode == pdc_pkg::PDC_SLEEP ##1 mode == pdc_pkg::PDC_ACTIVE);
    cov_wait_done: cover property (
        mode == pdc_pkg::PDC_WAKE_WAIT ##1 mode == pdc_pkg::PDC_ACTIVE);
    cov_subactive: cover property (
        mode == pdc_pkg::PDC_SUBACTIVE && o_clk_en);
endmodule // pdc_power_ctrl

/* pdc_power_ctrl_tb.sv */
`timescale 1ns/100ps
// ==========================================================================
// bench for power-down and clock control
module pdc_power_ctrl_tb;
    logic i_clk_sys = 1'b0;
    logic i_rst = 1'b1;
    logic [1:0] i_addr = 2'h0;
    logic [7:0] i_wr_data = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic i_sleep = 1'b0;
    logic i_wake = 1'b0;
    logic i_wdt_int_osc = 1'b0;
    logic i_watch_clk = 1'b0;
    logic [7:0] o_rd_data;
    logic [2:0] o_mode;
    logic o_cpu_run;
    logic o_periph_run;
    logic o_clk_en;
    logic [6:0] o_mod_standby;
    int n_fail = 0;
    int cmp_count = 0;
    int cyc = 0;
    int wdiv = 0;
    // short wait counts keep the run small
    int wait_exp [8] = '{32, 40, 48, 56, 64, 1024, 128, 16};

    pdc_power_ctrl #(
        .P_WAIT_CNT_0(32),
        .P_WAIT_CNT_1(40),
        .P_WAIT_CNT_2(48),
        .P_WAIT_CNT_3(56),
        .P_WAIT_CNT_4(64)
    ) u_pdc_power_ctrl (
        .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_addr(i_addr), .i_wr_data(i_wr_data),
        .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data), .i_sleep(i_sleep),
        .i_wake(i_wake), .i_wdt_int_osc(i_wdt_int_osc), .i_watch_clk(i_watch_clk),
        .o_mode(o_mode), .o_cpu_run(o_cpu_run), .o_periph_run(o_periph_run),
        .o_clk_en(o_clk_en), .o_mod_standby(o_mod_standby)
    );

    // ======================================================================
    // clocks and run limit
    always #2 i_clk_sys = ~i_clk_sys;
    // watch clock of ten system cycles, far slower than the system clock
    always @(posedge i_clk_sys) begin
        wdiv <= (wdiv == 4) ? 0 : wdiv + 1;
        if (wdiv == 4) begin
            i_watch_clk <= ~i_watch_clk;
        end
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            summarize();
        end
    end

    // ======================================================================
    // shared tasks
    task automatic chk(input logic [17:0] g, input logic [17:0] e);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wr_data <= d;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        @(posedge i_clk_sys);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1 chk(o_rd_data, e);
    endtask

    task automatic slp(input logic [2:0] m);
        @(posedge i_clk_sys);
        i_sleep <= 1'b1;
        @(posedge i_clk_sys);
        i_sleep <= 1'b0;
        #1 chk(o_mode, m);
        chk({o_cpu_run, o_periph_run}, {m == 3'h0 || m == 3'h2, m != 3'h4 && m != 3'h5});
    endtask

    task automatic wk(input logic [2:0] m);
        @(posedge i_clk_sys);
        i_wake <= 1'b1;
        @(posedge i_clk_sys);
        i_wake <= 1'b0;
        #1 chk(o_mode, m);
        chk({o_cpu_run, o_periph_run}, {m == 3'h0 || m == 3'h2, m != 3'h4 && m != 3'h5});
    endtask

    // counts cycles spent in wake wait, peripherals held off meanwhile
    task automatic wwait(input int n);
        logic [17:0] k;
        k = 0;
        while (o_mode === 3'h5 && k < 18'h00bb8) begin
            chk(o_periph_run, 0);
            k++;
            @(posedge i_clk_sys);
            #1;
        end
        chk(k, n);
        chk(o_mode, 0);
    endtask

    task automatic ticks(input int n, input int e);
        logic [17:0] k;
        k = 0;
        repeat (n) begin
            @(posedge i_clk_sys);
            #1 k += o_clk_en;
        end
        chk(k, e);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ======================================================================
    // main sequence
    initial begin
        repeat (16) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        rd(2'h0, 8'h00);
        rd(2'h1, 8'h00);
        rd(2'h2, 8'h00);
        chk(o_mod_standby, 0);
        // walk one standby bit at a time
        for (int i = 0; i < 7; i++) begin
            wr(2'h2, 8'h01 << i);
            @(posedge i_clk_sys);
            #1 chk(o_mod_standby, 7'h01 << i);
        end
        wr(2'h2, 8'hff);
        rd(2'h2, 8'h7f);
        // read data fall back to zero one cycle after the answer
        @(posedge i_clk_sys);
        #1 chk(o_rd_data, 8'h00);
        chk(o_mod_standby, 7'h7f);
        i_wdt_int_osc <= 1'b1;
        @(posedge i_clk_sys);
        #1 chk(o_mod_standby, 7'h77);
        i_wdt_int_osc <= 1'b0;
        wr(2'h2, 8'h00);
        // status index is read-only, other registers untouched
        wr(2'h3, 8'hff);
        // status: settle short, cpu running, mode active
        rd(2'h3, 8'h18);
        rd(2'h1, 8'h00);
        wr(2'h1, 8'h55);
        rd(2'h1, 8'h55);
        wr(2'h0, 8'hff);
        rd(2'h0, 8'hf0);
        wr(2'h0, 8'h00);
        wr(2'h1, 8'h00);
        // plain sleep and wake without wait
        slp(3'h1);
        // a second sleep while halted and a wake while running are ignored
        slp(3'h1);
        wk(3'h0);
        wk(3'h0);
        // new divider waits for a sleep before it takes hold
        wr(2'h1, 8'h10);
        ticks(128, 128);
        for (int d = 4; d < 8; d++) begin
            wr(2'h1, 8'h20 | (d << 2));
            slp(3'h0);
            repeat (8) @(posedge i_clk_sys);
            ticks(128, 128 >> (d - 1));
        end
        // subactive ratios from the watch clock
        for (int s = 0; s < 4; s++) begin
            wr(2'h1, 8'h60 | s);
            slp(3'h2);
            repeat (100) @(posedge i_clk_sys);
            ticks(800, 10 << (s < 2 ? s : 2));
        end
        // code 011 of the active divider still runs undivided
        wr(2'h1, 8'h2c);
        slp(3'h0);
        ticks(16, 16);
        // subsleep wakes through the wait, or to subactive when low speed
        wr(2'h0, 8'h70);
        wr(2'h1, 8'h80);
        slp(3'h3);
        wk(3'h5);
        wwait(16);
        wr(2'h1, 8'hc0);
        slp(3'h3);
        wk(3'h2);
        wr(2'h1, 8'h20);
        slp(3'h0);
        // standby with every wait select
        wr(2'h1, 8'h00);
        for (int s = 0; s < 8; s++) begin
            wr(2'h0, 8'h80 | (s << 4));
            slp(3'h4);
            wk(3'h5);
            wwait(wait_exp[s]);
        end
        summarize();
    end
endmodule // pdc_power_ctrl_tb
